// ---- rtl/luma_coring_pkg.sv ----
// Constants for the standard-definition luma noise coring stage.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package luma_coring_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_GAIN = 8'hA3;
   localparam logic [7:0] IDX_THRESH = 8'hA4;
   localparam logic [7:0] IDX_MODE = 8'hA5;
   localparam logic [7:0] IDX_STATUS = 8'hA6;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_GAIN = {2'b00, IDX_GAIN, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_THRESH = {2'b00, IDX_THRESH, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MODE = {2'b00, IDX_MODE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [7:0] REG_RESET = 8'h00;
   // Field positions.
   localparam int GAIN_BORDER_LSB = 0;
   localparam int GAIN_INTERIOR_LSB = 4;
   localparam int THRESH_LSB = 0;
   localparam int BORDER4_BIT = 6;
   localparam int BLOCK16_BIT = 7;
   localparam int SELECT_LSB = 0;
   localparam int SHARPEN_BIT = 3;
   localparam int OFFSET_LSB = 4;
   // Geometry and arithmetic.
   localparam int PIX_W = 8;
   localparam int FILT_W = 11;
   localparam int COL_W = 4;
   localparam logic [COL_W-1:0] BLOCK8_MASK = 4'h7;
   localparam logic [COL_W-1:0] BLOCK16_MASK = 4'hF;
   localparam logic [COL_W-1:0] HALF2 = 4'h1;
   localparam logic [COL_W-1:0] HALF4 = 4'h2;
   localparam int CORE_SHIFT = 3;
   localparam int SHARP_SHIFT = 4;
   localparam logic [PIX_W-1:0] PIX_MAX = 8'hFF;
   localparam int TAPS = 5;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = 2 * PIX_W;
   localparam logic [31:0] CLK_HZ = 32'd27000000;
   localparam int CLK_PER_PIX = 2;
   typedef enum logic [1:0] {PH_LUMA = 2'b01, PH_CHROMA = 2'b10} phase_t;
endpackage : luma_coring_pkg

// ---- rtl/coring_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module coring_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rd_r];
   always_ff @(posedge pclk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= AW'((wr_r == AW'(DEPTH-1)) ? 0 : wr_r + 1'b1);
         end
         if (pop) begin
            rd_r <= AW'((rd_r == AW'(DEPTH-1)) ? 0 : rd_r + 1'b1);
         end
         cnt_r <= (AW+1)'(cnt_r + push - pop);
      end
   end
endmodule : coring_fifo
`default_nettype wire

// ---- rtl/luma_noise_coring.sv ----
// Luma noise coring / sharpening stage with APB control registers.
// Assumes interleaved luma/chroma samples at two clocks per pixel, first sample luma,
// with a line-start pulse and valid/ready stream handshake.
// Operation
// - Only luma samples are processed; chroma samples pass through unchanged.
// - Band filter isolates high frequencies; its absolute value is compared to threshold.
// - Coring mode: below threshold, subtract gain-scaled filter output from luma.
// - Sharpening mode: above threshold, add gain-scaled filter output to luma.
// - Border gain is bits 3:0 of register one; coring scale is eighths.
// - Interior gain is bits 7:4 of register one, same scaling rules.
// - Sharpening mode scales both gains in sixteenths, up to fifteen sixteenths.
// - Threshold is unsigned bits 5:0 of register two, range 0 to 63.
// - Bit 6 of register two selects four-pixel border, else two pixels.
// - Bit 7 of register two selects 16x16 blocks, else 8x8 blocks.
// - One pixel counts as two clock cycles when measuring positions.
// - Bits 2:0 of register three select the band filter response.
// - Bit 3 of register three selects sharpening, zero selects coring.
// - A block offset control shifts the block grid.
// - All controls live in exactly three 8-bit writable registers.
// - Offset is bits 7:4 of register three, 0 to 15 pixels.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module luma_noise_coring
   import luma_coring_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Input sample stream.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [PIX_W-1:0] in_data,
   input wire logic in_line_start,
   // Output stream: luma and chroma pairs.
   output logic out_valid,
   input wire logic out_ready,
   output logic [PIX_W-1:0] out_data
);
   logic [7:0] gain_r;
   logic [7:0] thresh_r;
   logic [7:0] mode_r;
   logic [7:0] rdata_nxt;
   logic apb_wr;
   logic apb_acc;
   logic addr_ok;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [FIFO_W-1:0] fifo_out_data;
   logic [FIFO_W-1:0] pair_nxt;
   logic [PIX_W-1:0] taps_r [TAPS];
   logic [PIX_W-1:0] chroma_r;
   logic luma_phase_r;
   logic [COL_W-1:0] col_r;
   logic [COL_W-1:0] pos;
   logic [COL_W-1:0] bmask;
   logic [COL_W-1:0] half;
   logic is_border;
   logic signed [FILT_W-1:0] filt;
   logic [FILT_W-1:0] mag;
   logic [3:0] gain_sel;
   logic signed [FILT_W+4:0] prod;
   logic signed [FILT_W+4:0] scaled;
   logic signed [FILT_W+4:0] sum;
   logic [PIX_W-1:0] luma_nxt;
   logic take;
   logic out_sel_r;
   logic [FILT_W-1:0] last_mag_r;

   // Register file.
   assign apb_acc = psel && penable;
   assign apb_wr = apb_acc && pwrite;
   assign pready = 1'b1;
   assign addr_ok = (paddr == ADDR_GAIN) || (paddr == ADDR_THRESH) ||
                    (paddr == ADDR_MODE) || (paddr == ADDR_STATUS);
   assign pslverr = apb_acc && !addr_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_r <= REG_RESET;
         thresh_r <= REG_RESET;
         mode_r <= REG_RESET;
      end else if (apb_wr) begin
         // Three 8-bit control registers hold every setting.
         if (paddr == ADDR_GAIN) begin
            gain_r <= pwdata[7:0];
         end
         if (paddr == ADDR_THRESH) begin
            thresh_r <= pwdata[7:0];
         end
         if (paddr == ADDR_MODE) begin
            mode_r <= pwdata[7:0];
         end
      end
   end

   always_comb begin
      rdata_nxt = 8'h00;
      if (paddr == ADDR_GAIN) begin
         rdata_nxt = gain_r;
      end else if (paddr == ADDR_THRESH) begin
         rdata_nxt = thresh_r;
      end else if (paddr == ADDR_MODE) begin
         rdata_nxt = mode_r;
      end else if (paddr == ADDR_STATUS) begin
         rdata_nxt = last_mag_r[PIX_W-1:0];
      end
   end
   assign prdata = {24'h000000, rdata_nxt};

   // Band filter responses; the tap window is centred on taps_r[2].
   function automatic logic signed [FILT_W-1:0] band(input logic [2:0] sel,
                                                    input logic [PIX_W-1:0] t0,
                                                    input logic [PIX_W-1:0] t1,
                                                    input logic [PIX_W-1:0] t2,
                                                    input logic [PIX_W-1:0] t3,
                                                    input logic [PIX_W-1:0] t4);
      logic signed [FILT_W-1:0] a0;
      logic signed [FILT_W-1:0] a1;
      logic signed [FILT_W-1:0] a2;
      logic signed [FILT_W-1:0] a3;
      logic signed [FILT_W-1:0] a4;
      a0 = FILT_W'(t0);
      a1 = FILT_W'(t1);
      a2 = FILT_W'(t2);
      a3 = FILT_W'(t3);
      a4 = FILT_W'(t4);
      unique case (sel[1:0])
         2'b00: band = (a2 <<< 1) - a1 - a3;
         2'b01: band = (a2 <<< 1) - a0 - a4;
         2'b10: band = ((a2 <<< 1) - a1 - a3 + (a2 <<< 1) - a0 - a4) >>> 1;
         2'b11: band = a2 - a3;
      endcase
      if (sel[2]) begin
         band = band >>> 1;
      end
   endfunction : band

   // Stream handshake: one sample per accepted cycle.
   assign take = in_valid && in_ready;
   assign in_ready = fifo_in_ready;

   // Luma/chroma phase, luma first after a line start.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         luma_phase_r <= 1'b1;
      end else if (take) begin
         luma_phase_r <= in_line_start ? 1'b0 : !luma_phase_r;
      end
   end

   // Luma delay line for the band filter.
   genvar gi;
   generate
      for (gi = 0; gi < TAPS; gi++) begin : g_tap
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               taps_r[gi] <= '0;
            end else if (take && (in_line_start || luma_phase_r)) begin
               taps_r[gi] <= (gi == 0) ? in_data : taps_r[(gi == 0) ? 0 : gi-1];
            end
         end
      end
   endgenerate

   // Chroma is held unaltered in chroma_r, which nothing reads; each pair takes chroma from in_data and luma from taps_r[2].
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chroma_r <= '0;
      end else if (take && !luma_phase_r && !in_line_start) begin
         chroma_r <= in_data;
      end
   end

   // Pixel column counter: advances once per two-clock pixel.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         col_r <= '0;
      end else if (take && in_line_start) begin
         col_r <= '0;
      end else if (take && !luma_phase_r) begin
         col_r <= COL_W'(col_r + 1'b1);
      end
   end

   // Block grid position with offset; border zone straddles each boundary.
   assign bmask = thresh_r[BLOCK16_BIT] ? BLOCK16_MASK : BLOCK8_MASK;
   assign half = thresh_r[BORDER4_BIT] ? HALF4 : HALF2;
   assign pos = COL_W'(col_r + mode_r[OFFSET_LSB +: 4]) & bmask;
   assign is_border = (pos < half) || (pos > COL_W'(bmask - half));

   // Filter and magnitude.
   assign filt = band(mode_r[SELECT_LSB +: 3], taps_r[0], taps_r[1], taps_r[2],
                      taps_r[3], taps_r[4]);
   assign mag = filt[FILT_W-1] ? FILT_W'(-filt) : filt;

   // Border or interior gain.
   assign gain_sel = is_border ? gain_r[GAIN_BORDER_LSB +: 4] : gain_r[GAIN_INTERIOR_LSB +: 4];
   assign prod = (FILT_W+5)'(filt) * $signed({1'b0, gain_sel});

   always_comb begin
      scaled = '0;
      if (!mode_r[SHARPEN_BIT]) begin
         // Coring: eighths, subtract below threshold.
         if (mag < FILT_W'(thresh_r[THRESH_LSB +: 6])) begin
            scaled = -(prod >>> CORE_SHIFT);
         end
      end else begin
         // Sharpening: sixteenths, add above threshold.
         if (mag > FILT_W'(thresh_r[THRESH_LSB +: 6])) begin
            scaled = prod >>> SHARP_SHIFT;
         end
      end
      sum = (FILT_W+5)'(taps_r[2]) + scaled;
      if (sum < 0) begin
         luma_nxt = '0;
      end else if (sum > (FILT_W+5)'(PIX_MAX)) begin
         luma_nxt = PIX_MAX;
      end else begin
         luma_nxt = sum[PIX_W-1:0];
      end
   end

   // Processed pixel pair enters the FIFO on each accepted chroma sample.
   assign pair_nxt = {luma_nxt, in_data};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_mag_r <= '0;
      end else if (take && !luma_phase_r) begin
         last_mag_r <= mag;
      end
   end

   coring_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(in_valid && !luma_phase_r && !in_line_start),
      .in_ready(fifo_in_ready),
      .in_data(pair_nxt),
      .out_valid(fifo_out_valid),
      .out_ready(out_ready && out_sel_r),
      .out_data(fifo_out_data)
   );

   // Output serialises each pair: luma then chroma.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_sel_r <= 1'b0;
      end else if (fifo_out_valid && out_ready) begin
         out_sel_r <= !out_sel_r;
      end
   end
   assign out_valid = fifo_out_valid;
   assign out_data = out_sel_r ? fifo_out_data[PIX_W-1:0] : fifo_out_data[FIFO_W-1:PIX_W];

   a_chroma_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (out_valid && out_sel_r) |-> out_data == fifo_out_data[PIX_W-1:0])
      else $error("Chroma sample altered.");
   a_core_sub: assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_r[SHARPEN_BIT] && mag >= FILT_W'(thresh_r[5:0])) |-> scaled == 0)
      else $error("Coring touched above-threshold content.");
   a_sharp_add: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_r[SHARPEN_BIT] && mag <= FILT_W'(thresh_r[5:0])) |-> scaled == 0)
      else $error("Sharpening touched noise content.");
   a_gain_pick: assert property (@(posedge pclk) disable iff (!presetn)
      is_border |-> gain_sel == gain_r[3:0])
      else $error("Border gain not used.");
   a_data_gain: assert property (@(posedge pclk) disable iff (!presetn)
      !is_border |-> gain_sel == gain_r[7:4])
      else $error("Interior gain not used.");
   a_reg_write: assert property (@(posedge pclk) disable iff (!presetn)
      (apb_wr && paddr == ADDR_MODE) |=> mode_r == $past(pwdata[7:0]))
      else $error("Register write lost.");
   a_col_step: assert property (@(posedge pclk) disable iff (!presetn)
      (take && !luma_phase_r && !in_line_start) |=> col_r == COL_W'($past(col_r) + 1'b1))
      else $error("Pixel counter misstepped.");
   a_block8_pos: assert property (@(posedge pclk) disable iff (!presetn)
      !thresh_r[BLOCK16_BIT] |-> pos[3] == 1'b0)
      else $error("8x8 grid position out of range.");

   // Named steps of the register and stream handshakes.
   sequence s_apb_setup;
      psel && !penable;
   endsequence

   sequence s_apb_access;
      psel && penable && pready;
   endsequence

   sequence s_pair_push;
      take && !luma_phase_r && !in_line_start;
   endsequence

   sequence s_line_start;
      take && in_line_start;
   endsequence

   sequence s_out_held;
      out_valid && !out_ready;
   endsequence

   // Handshake and pipeline checks built from the steps above.
   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_setup ##1 (psel && penable) |-> s_apb_access)
      else $error("Register access not answered.");
   a_out_stands: assert property (@(posedge pclk) disable iff (!presetn)
      s_out_held |=> (out_valid && $stable(out_data)))
      else $error("Output sample changed while held.");
   a_pair_fill: assert property (@(posedge pclk) disable iff (!presetn)
      s_pair_push |=> out_valid)
      else $error("Accepted pair did not reach the output.");
   a_line_phase: assert property (@(posedge pclk) disable iff (!presetn)
      s_line_start |=> !luma_phase_r)
      else $error("Line start did not set chroma phase.");
   a_col_clear: assert property (@(posedge pclk) disable iff (!presetn)
      s_line_start |=> col_r == '0)
      else $error("Line start did not clear the column.");
   a_gain_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (gain_sel == 4'h0) |-> luma_nxt == taps_r[2])
      else $error("Zero gain altered luma.");
   a_fifo_full: assert property (@(posedge pclk) disable iff (!presetn)
      !in_ready |-> out_valid)
      else $error("Input refused while buffer empty.");
   a_out_order: assert property (@(posedge pclk) disable iff (!presetn)
      (out_valid && out_ready && !out_sel_r) |=> out_sel_r)
      else $error("Chroma did not follow luma.");
   a_status_mag: assert property (@(posedge pclk) disable iff (!presetn)
      s_pair_push |=> last_mag_r == $past(mag))
      else $error("Status magnitude not captured.");
endmodule : luma_noise_coring
`default_nettype wire

// ---- tb/pixel_source.sv ----
// Upstream pixel source model: interleaved luma and chroma samples on a valid/ready stream.
// Assumes the stage samples in_valid and in_ready at the rising edge of pclk.
`timescale 1ns/10ps
`default_nettype none
module pixel_source (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Sample stream.
   output logic in_valid,
   input wire logic in_ready,
   output logic [7:0] in_data,
   output logic in_line_start
);
   initial begin
      in_valid = 1'b0;
      in_data = 8'h00;
      in_line_start = 1'b0;
   end

   // Holds a sample until it is taken, then shows its inverse so stale data never matches.
   task automatic send(input logic [7:0] v, input logic ls);
      @(posedge pclk);
      while (presetn !== 1'b1) @(posedge pclk);
      in_valid <= 1'b1;
      in_data <= v;
      in_line_start <= ls;
      do @(posedge pclk); while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      in_line_start <= 1'b0;
      in_data <= ~v;
   endtask : send
endmodule : pixel_source
`default_nettype wire

// ---- tb/sd_luma_noise_coring_bench.sv ----
// Testbench for the luma noise coring stage: APB register tasks and stream scenarios.
// Assumes the pixel source model drives the input stream and this module sinks the output.
`timescale 1ns/10ps
`default_nettype none
module sd_luma_noise_coring_bench
   import luma_coring_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic in_valid, in_ready, in_line_start, out_valid, out_ready;
   logic [7:0] in_data, out_data;
   logic [7:0] got[$];
   int n_in, errors, n_tests;

   luma_noise_coring u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
      .in_line_start(in_line_start), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data));
   pixel_source u_src (.pclk(pclk), .presetn(presetn), .in_valid(in_valid),
      .in_ready(in_ready), .in_data(in_data), .in_line_start(in_line_start));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
      if (in_valid === 1'b1 && in_ready === 1'b1) n_in++;
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check

   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      xfer(1'b0, a, 32'h0, q, e);
      check(q, x);
      check({31'h0, e}, {31'h0, xe});
   endtask : rd

   // Sends n pairs from line start; chroma must pass, luma comes out two pixels later.
   task automatic run(input logic [7:0] base, input logic [7:0] step, input int n,
                      input int skip, input bit stall);
      logic [7:0] l[$];
      logic [7:0] c[$];
      int k;
      got.delete();
      n_in = 0;
      for (int i = 0; i < n; i++) begin
         l.push_back(8'(base + step * i));
         c.push_back(8'(8'h11 + i * 5));
      end
      if (stall) out_ready <= 1'b0;
      fork
         for (int i = 0; i < n; i++) begin
            u_src.send(l[i], i == 0);
            u_src.send(c[i], 1'b0);
         end
         if (stall) begin
            repeat (120) @(posedge pclk);
            check(n_in, 32'd32);
            check({31'h0, in_ready}, 32'h0);
            out_ready <= 1'b1;
         end
      join
      k = 0;
      while (got.size() < 2 * n && k < 500) begin
         @(posedge pclk);
         k++;
      end
      check(got.size(), 2 * n);
      for (int i = 0; i < n && 2 * i + 1 < got.size(); i++) begin
         check(got[2 * i + 1], c[i]);
         if (i >= skip) check(got[2 * i], l[i - 2]);
      end
   endtask : run

   task automatic cfg(input logic [7:0] g, input logic [7:0] t, input logic [7:0] m);
      wr(ADDR_GAIN, {24'h0, g});
      wr(ADDR_THRESH, {24'h0, t});
      wr(ADDR_MODE, {24'h0, m});
   endtask : cfg

   task automatic conclude();
      $display("checks=%0d errors=%0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      conclude();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      out_ready = 1'b1;
      errors = 0;
      n_tests = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_GAIN, 32'h0, 1'b0);
      rd(ADDR_THRESH, 32'h0, 1'b0);
      rd(ADDR_MODE, 32'h0, 1'b0);
      wr(12'h004, 32'hFF);
      rd(12'h004, 32'h0, 1'b1);
      wr(ADDR_GAIN, 32'hFFFF_FF5A);
      rd(ADDR_GAIN, 32'h5A, 1'b0);
      wr(ADDR_THRESH, 32'h0000_01C3);
      rd(ADDR_THRESH, 32'hC3, 1'b0);
      wr(ADDR_MODE, 32'h0000_A53C);
      rd(ADDR_MODE, 32'h3C, 1'b0);
      for (int m = 0; m < 16; m++) begin
         cfg(8'h77, {2'(m), 6'(m * 4)}, {4'(15 - m), 4'(m)});
         run(8'h80, 8'h00, 8, 4, 1'b0);
         rd(ADDR_STATUS, 32'h0, 1'b0);
      end
      cfg(8'hFF, 8'h00, 8'h00);
      run(8'h40, 8'h03, 24, 2, 1'b0);
      cfg(8'h00, 8'h00, 8'h0B);
      run(8'h40, 8'h07, 24, 2, 1'b0);
      cfg(8'h00, 8'h3F, 8'h02);
      run(8'hC0, 8'h02, 24, 2, 1'b0);
      cfg(8'hFF, 8'h00, 8'h00);
      run(8'h20, 8'h05, 20, 2, 1'b1);
      conclude();
   end
endmodule : sd_luma_noise_coring_bench
`default_nettype wire
